// file: sdram_defines.svh
// timing counts and field widths for the sdram command link
`ifndef SDRAM_DEFINES_SVH
`define SDRAM_DEFINES_SVH
`define CLK_PERIOD_NS 8
`define POWERUP_WAIT_NS 100000
`define POWERUP_WAIT_CYC ((`POWERUP_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REFRESH_CYCLE_TIME_NS 70
`define REFRESH_CYCLE_TIME_CYC ((`REFRESH_CYCLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SELF_REFRESH_EXIT_DELAY_NS 70
`define SELF_REFRESH_EXIT_DELAY_RAW ((`SELF_REFRESH_EXIT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SELF_REFRESH_EXIT_MIN_CYC 2
`define SELF_REFRESH_EXIT_DELAY_CYC ((`SELF_REFRESH_EXIT_DELAY_RAW > `SELF_REFRESH_EXIT_MIN_CYC) ? `SELF_REFRESH_EXIT_DELAY_RAW : `SELF_REFRESH_EXIT_MIN_CYC)
`define WRITE_RECOVERY_CYC 2
`define PRECHARGE_PERIOD_NS 20
`define PRECHARGE_PERIOD_CYC ((`PRECHARGE_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ROW_INTERVAL_NS 15600
`define ROW_INTERVAL_CYC (`ROW_INTERVAL_NS / `CLK_PERIOD_NS)
`define SELF_REFRESH_MIN_NS 64000
`define SELF_REFRESH_MIN_CYC ((`SELF_REFRESH_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_REFRESH_COUNT 2
`define COL_BITS 8
`define DATA_BITS 32
`define ADDR_BITS 12
`endif

// file: sdram_pkg.sv
// types shared by both ends of the sdram command link
`default_nettype none
package sdram_pkg;
   // command encoding {cs_n, ras_n, cas_n, we_n}
   typedef enum logic [3:0] {
      CMD_INHIBIT = 4'h8,
      CMD_NOP = 4'h7,
      CMD_ACTIVE = 4'h3,
      CMD_READ = 4'h5,
      CMD_WRITE = 4'h4,
      CMD_BURST_STOP = 4'h6,
      CMD_PRECHARGE = 4'h2,
      CMD_REFRESH = 4'h1,
      CMD_LOAD_MODE = 4'h0
   } cmd_t;
endpackage
`default_nettype wire

// file: sdram_link_if.sv
// command link between memory controller and sdram
`timescale 1ns/10ps
`default_nettype none
interface sdram_link_if;
   logic cke;
   logic [3:0] cmd;
   logic [1:0] bank;
   logic [11:0] addr;
   logic [31:0] dq_ctl_out;
   logic dq_ctl_oe;
   logic [31:0] dq_mem_out;
   logic dq_mem_oe;
   logic [31:0] dq;
   // resolved data wire level
   assign dq = dq_mem_oe ? dq_mem_out : (dq_ctl_oe ? dq_ctl_out : 32'h0);
   modport ctl (output cke, cmd, bank, addr, dq_ctl_out, dq_ctl_oe, input dq_mem_out, dq_mem_oe);
   modport mem (input cke, cmd, bank, addr, dq_ctl_out, dq_ctl_oe, output dq_mem_out, dq_mem_oe);
endinterface
`default_nettype wire

// file: sdram_mem_end.sv
// sdram device end: command decode, storage, self refresh
`timescale 1ns/10ps
`default_nettype none
module sdram_mem_end import sdram_pkg::*; #(
   parameter bit AUTOMOTIVE_GRADE = 1'b0
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // link
   sdram_link_if.mem link,
   // status
   output logic in_self_refresh,
   output logic row_open_any
);
`include "sdram_defines.svh"
   // small storage: 4 banks x 4096 rows x 256 columns would be large; keep 4 banks x 16 words
   typedef struct packed {
      logic [3:0] open;
      logic [3:0][11:0] row;
      logic self_ref;
      logic [1:0] rd_pipe;
      logic [31:0] rd_data;
      logic oe;
      logic [3:0][15:0][31:0] mem;
   } mem_st_t;
   mem_st_t s_q, s_d;
   logic [3:0] idx;

   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      idx = link.addr[3:0]; // column index uses A0-A3 only; A4-A9, A11 ignored [RULE_13]
      s_d.rd_pipe = {s_q.rd_pipe[0], 1'b0};
      s_d.oe = s_q.rd_pipe[1];
      if (s_q.self_ref) begin
         // no upper limit on self refresh stay [RULE_06]
         if (link.cke) begin
            s_d.self_ref = 1'b0;
         end
      end else if (link.cke) begin
         case (cmd_t'(link.cmd))
            CMD_ACTIVE: begin
               s_d.open[link.bank] = 1'b1;
               s_d.row[link.bank] = link.addr;
            end
            CMD_READ: begin
               s_d.rd_pipe[0] = 1'b1;
               s_d.rd_data = s_q.mem[link.bank][idx];
               if (link.addr[10]) begin
                  s_d.open[link.bank] = 1'b0;
               end
            end
            CMD_WRITE: begin
               if (link.dq_ctl_oe) begin
                  s_d.mem[link.bank][idx] = link.dq_ctl_out;
               end
               if (link.addr[10]) begin
                  s_d.open[link.bank] = 1'b0;
               end
            end
            CMD_PRECHARGE: begin
               // rows stay open until precharge or a read/write with A10 set [RULE_14]
               if (link.addr[10]) begin
                  s_d.open = 4'h0;
               end else begin
                  s_d.open[link.bank] = 1'b0;
               end
            end
            CMD_LOAD_MODE: begin
               s_d.rd_pipe = 2'h0; // outputs high-z after init command [RULE_11]
               s_d.oe = 1'b0;
            end
            default: begin
            end
         endcase
      end else if (cmd_t'(link.cmd) == CMD_REFRESH && !AUTOMOTIVE_GRADE) begin
         s_d.self_ref = 1'b1; // automotive parts refuse self refresh [RULE_07]
      end
   end

   // state register
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign link.dq_mem_out = s_q.rd_data;
   assign link.dq_mem_oe = s_q.oe;
   assign in_self_refresh = s_q.self_ref;
   assign row_open_any = |s_q.open;
endmodule
`default_nettype wire

// file: sdram_ctl_end.sv
// memory controller end: init, refresh, self refresh and access sequencing
//
// Contract
// RULE_01: clock stays constant during accesses; cke throttles
// RULE_02: only nop during refresh cycle time
// RULE_03: self refresh exit delay at least two clocks
// RULE_04: no self refresh reentry before full refresh
// RULE_05: early reentry only after 64us stay, paired refreshes
// RULE_06: self refresh has no maximum duration
// RULE_07: automotive parts lack self refresh
// RULE_08: write recovery before every precharge
// RULE_09: two clocks write recovery above 100 MHz
// RULE_10: mode load before or after init refreshes
// RULE_11: device outputs high-z after init command
// RULE_12: refresh continues during power-down
// RULE_13: column ignores A8, A9, A11
// RULE_14: full-page burst leaves row open
// RULE_15: 100us wait then two refreshes
// RULE_16: exit delay at least 70 ns
// RULE_17: waits are rounded-up counts issuing nop
// RULE_18: refresh request counter keeps average rate
`timescale 1ns/10ps
`default_nettype none
`include "sdram_defines.svh"
module sdram_ctl_end import sdram_pkg::*; #(
   parameter int POWERUP_WAIT_CYC = `POWERUP_WAIT_CYC,
   parameter int ROW_INTERVAL_CYC = `ROW_INTERVAL_CYC,
   parameter int SELF_REFRESH_MIN_CYC = `SELF_REFRESH_MIN_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // user requests
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [1:0] req_bank,
   input wire logic [11:0] req_row,
   input wire logic [7:0] req_col,
   input wire logic [31:0] req_wdata,
   input wire logic sleep_req,
   input wire logic power_down_req,
   // user answers
   output logic req_ready,
   output logic rd_valid,
   output logic [31:0] rd_data,
   output logic init_done,
   // link
   sdram_link_if.ctl link
);
   // this controller targets parts that support self refresh
   localparam bit AUTOMOTIVE = 1'b0;
   typedef enum logic [9:0] {
      ST_POWERUP = 10'h001,
      ST_INIT_REF = 10'h002,
      ST_LOAD_MODE = 10'h004,
      ST_IDLE = 10'h008,
      ST_REFRESH = 10'h010,
      ST_ACT = 10'h020,
      ST_RW = 10'h040,
      ST_RECOVER = 10'h080,
      ST_SELF = 10'h100,
      ST_EXIT = 10'h200
   } state_t;
   typedef struct packed {
      state_t st;
      logic [16:0] wait_cnt;
      logic [1:0] wake_cnt;
      logic [3:0] ref_owed;
      logic [11:0] ref_tmr;
      logic [12:0] since_exit;
      logic [14:0] self_stay;
      logic reenter_ok;
      logic cke;
      logic [3:0] cmd;
      logic [1:0] bank;
      logic [11:0] addr;
      logic [31:0] wdata;
      logic doe;
      logic wr;
      logic ready;
      logic [2:0] rd_pipe;
      logic rvalid;
      logic [31:0] rdata;
      logic done;
   } ctl_st_t;
   ctl_st_t s_q, s_d;

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.cmd = CMD_NOP; // every wait issues nop [RULE_17]
      s_d.doe = 1'b0;
      s_d.ready = 1'b0;
      s_d.rvalid = s_q.rd_pipe[2];
      s_d.rd_pipe = {s_q.rd_pipe[1:0], 1'b0};
      if (s_q.rd_pipe[2]) begin
         s_d.rdata = link.dq_mem_out;
      end
      // refresh owed counter runs in every state but ST_SELF, power-down too [RULE_18] [RULE_12]
      if (s_q.ref_tmr == 12'(ROW_INTERVAL_CYC - 1)) begin
         s_d.ref_tmr = 12'h0;
         if (s_q.st != ST_SELF && s_q.ref_owed != 4'hf) begin
            s_d.ref_owed = s_q.ref_owed + 4'h1;
         end
      end else begin
         s_d.ref_tmr = s_q.ref_tmr + 12'h1;
      end
      if (s_q.wait_cnt != 17'h0) begin
         s_d.wait_cnt = s_q.wait_cnt - 17'h1;
      end
      if (s_q.since_exit != 13'h1fff && s_q.st != ST_SELF) begin
         s_d.since_exit = s_q.since_exit + 13'h1;
      end
      case (s_q.st)
         ST_POWERUP: begin
            if (s_q.wait_cnt == 17'h0) begin // 100us pause [RULE_15]
               s_d.st = ST_INIT_REF;
               s_d.wake_cnt = 2'(`WAKE_REFRESH_COUNT);
            end
         end
         ST_INIT_REF: begin
            if (s_q.wait_cnt == 17'h0) begin
               if (s_q.wake_cnt == 2'h0) begin
                  s_d.st = ST_LOAD_MODE; // mode load after refreshes [RULE_10]
               end else begin
                  s_d.cmd = CMD_REFRESH; // two wake refreshes [RULE_15]
                  s_d.wake_cnt = s_q.wake_cnt - 2'h1;
                  s_d.wait_cnt = 17'(`REFRESH_CYCLE_TIME_CYC); // [RULE_02]
               end
            end
         end
         ST_LOAD_MODE: begin
            s_d.cmd = CMD_LOAD_MODE;
            s_d.addr = 12'h027; // full page, latency 2, sequential
            s_d.wait_cnt = 17'h2;
            s_d.done = 1'b1;
            s_d.ref_owed = 4'h0;
            s_d.st = ST_IDLE;
         end
         ST_IDLE: begin
            s_d.cke = !power_down_req || s_q.ref_owed != 4'h0; // wake to refresh [RULE_12]
            if (s_q.wait_cnt != 17'h0 || !s_q.cke) begin
               s_d.st = ST_IDLE;
            end else if (s_q.ref_owed != 4'h0) begin
               s_d.cmd = CMD_REFRESH; // refresh wins over accesses [RULE_18]
               s_d.ref_owed = s_d.ref_owed - 4'h1;
               s_d.wait_cnt = 17'(`REFRESH_CYCLE_TIME_CYC); // nop only [RULE_02]
               if (s_q.since_exit >= 13'(2 * ROW_INTERVAL_CYC / 1024)) begin
                  s_d.reenter_ok = 1'b1;
               end
            end else if (sleep_req && s_q.reenter_ok && !AUTOMOTIVE) begin
               s_d.cmd = CMD_REFRESH; // self refresh entry, not on automotive [RULE_07] [RULE_04]
               s_d.cke = 1'b0;
               s_d.self_stay = 15'h0;
               s_d.st = ST_SELF;
            end else if (req_valid) begin
               s_d.ready = 1'b1;
               s_d.cmd = CMD_ACTIVE;
               s_d.bank = req_bank;
               s_d.addr = req_row;
               s_d.wr = req_write;
               s_d.wdata = req_wdata;
               s_d.wait_cnt = 17'(`PRECHARGE_PERIOD_CYC);
               s_d.since_exit = {5'h0, req_col};
               s_d.st = ST_ACT;
            end
         end
         ST_ACT: begin
            // fixed clock through the access, cke only [RULE_01]
            if (s_q.wait_cnt == 17'h0) begin
               s_d.cmd = s_q.wr ? CMD_WRITE : CMD_READ;
               s_d.addr = {4'h0, s_q.since_exit[7:0]}; // A8, A9, A11 low [RULE_13]
               s_d.doe = s_q.wr;
               s_d.rd_pipe[0] = !s_q.wr;
               s_d.since_exit = 13'h1fff;
               s_d.st = ST_RW;
            end
         end
         ST_RW: begin
            // full-page burst ended by burst stop, row left open [RULE_14]
            s_d.cmd = CMD_BURST_STOP;
            s_d.wait_cnt = 17'(`WRITE_RECOVERY_CYC); // two clocks at 125 MHz [RULE_08] [RULE_09]
            s_d.st = ST_RECOVER;
         end
         ST_RECOVER: begin
            if (s_q.wait_cnt == 17'h0) begin
               s_d.cmd = CMD_PRECHARGE;
               s_d.addr = 12'h400;
               s_d.wait_cnt = 17'(`PRECHARGE_PERIOD_CYC);
               s_d.st = ST_IDLE;
            end
         end
         ST_SELF: begin
            if (s_q.self_stay != 15'h7fff) begin
               s_d.self_stay = s_q.self_stay + 15'h1;
            end
            if (!sleep_req) begin
               s_d.cke = 1'b1;
               // early reentry needs 64us stay [RULE_05]
               s_d.reenter_ok = s_q.self_stay >= 15'(SELF_REFRESH_MIN_CYC);
               s_d.since_exit = 13'h0;
               s_d.ref_owed = 4'h0;
               s_d.wait_cnt = 17'(`SELF_REFRESH_EXIT_DELAY_CYC); // [RULE_03] [RULE_16]
               s_d.st = ST_EXIT;
            end
         end
         ST_EXIT: begin
            if (s_q.wait_cnt == 17'h0) begin
               s_d.st = ST_IDLE;
            end
         end
         default: begin
            s_d.st = ST_POWERUP;
         end
      endcase
   end

   // state register
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s_q <= '0;
         s_q.st <= ST_POWERUP;
         s_q.wait_cnt <= 17'(POWERUP_WAIT_CYC);
         s_q.cke <= 1'b1;
         s_q.cmd <= CMD_NOP;
         s_q.reenter_ok <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign link.cke = s_q.cke;
   assign link.cmd = s_q.cmd;
   assign link.bank = s_q.bank;
   assign link.addr = s_q.addr;
   assign link.dq_ctl_out = s_q.wdata;
   assign link.dq_ctl_oe = s_q.doe;
   assign req_ready = s_q.ready;
   assign rd_valid = s_q.rvalid;
   assign rd_data = s_q.rdata;
   assign init_done = s_q.done;
endmodule
`default_nettype wire

// file: sdram_link_properties.sv
// assertions on the sdram command link between the two ends
`timescale 1ns/10ps
`default_nettype none
module sdram_link_properties import sdram_pkg::*; #(
   parameter int POWERUP_WAIT_CYC = 20,
   parameter int ROW_INTERVAL_CYC = 64
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // link
   input wire logic cke,
   input wire logic [3:0] cmd,
   input wire logic dq_ctl_oe,
   input wire logic dq_mem_oe
);
   logic sr_q;
   logic [15:0] up_q;
   logic [1:0] ref_q;
   logic [15:0] gap_q;
   logic idle;
   // --------------------------------
   // helper state
   // --------------------------------
   // nop or inhibit on the link
   assign idle = (cmd == CMD_NOP) || (cmd == CMD_INHIBIT);
   // self refresh flag, age, refresh count, gap since refresh
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sr_q <= 1'b0;
         up_q <= 16'h0;
         ref_q <= 2'h0;
         gap_q <= 16'h0;
      end else begin
         if (cmd == CMD_REFRESH && !cke) begin
            sr_q <= 1'b1;
         end else if (cke) begin
            sr_q <= 1'b0;
         end
         if (up_q != 16'hffff) begin
            up_q <= up_q + 16'h1;
         end
         if (cmd == CMD_REFRESH && cke && ref_q != 2'h3) begin
            ref_q <= ref_q + 2'h1;
         end
         gap_q <= (cmd == CMD_REFRESH || sr_q) ? 16'h0 : gap_q + 16'h1;
      end
   end
   // --------------------------------
   // properties
   // --------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   a_powerup_wait_quiet: assert property ((up_q < POWERUP_WAIT_CYC - 1) |-> idle)
      else $error("command during power-up wait");
   a_init_two_refresh: assert property (cmd == CMD_ACTIVE |-> ref_q >= 2'h2)
      else $error("activate before two refreshes");
   a_refresh_cycle_nop: assert property (cmd == CMD_REFRESH && cke |=> idle [*8])
      else $error("command inside refresh cycle time");
   a_exit_delay_hold: assert property ($fell(sr_q) |-> (cmd != CMD_ACTIVE) [*8])
      else $error("activate too soon after self refresh exit");
   a_write_recovery_gap: assert property (cmd == CMD_WRITE |-> dq_ctl_oe ##1 (cmd != CMD_PRECHARGE) [*2])
      else $error("precharge inside write recovery");
   a_load_outputs_off: assert property (cmd == CMD_LOAD_MODE |=> !dq_mem_oe [*2])
      else $error("device drives data after mode load");
   a_refresh_gap_bound: assert property (gap_q <= ROW_INTERVAL_CYC + 32)
      else $error("refresh interval overrun");
   a_precharge_wait: assert property (cmd == CMD_PRECHARGE |=> (cmd != CMD_ACTIVE) [*2])
      else $error("activate inside precharge period");
   a_self_refresh_quiet: assert property (sr_q |-> idle && !dq_mem_oe)
      else $error("link busy during self refresh");
endmodule
`default_nettype wire

// file: test_sdram_refresh_write_recovery_rules.sv
// self-checking bench for both ends of the sdram command link
`timescale 1ns/10ps
`default_nettype none
module test_sdram_refresh_write_recovery_rules import sdram_pkg::*;;
   logic sys_clk, sys_rst, req_valid, req_write, sleep_req, power_down_req;
   logic [1:0] req_bank;
   logic [11:0] req_row;
   logic [7:0] req_col;
   logic [31:0] req_wdata, rd_data, q;
   logic req_ready, rd_valid, init_done, in_self_refresh, row_open_any, at_self_refresh;
   int num_errors, checked, cyc, refs, cke_low, at_seen, r0;
   // --------------------------------
   // two linked pairs, second with automotive device
   // --------------------------------
   sdram_link_if link();
   sdram_link_if link_at();
   // short power-up wait and refresh tick; reentry stay keeps its real default
   sdram_ctl_end #(.POWERUP_WAIT_CYC(20), .ROW_INTERVAL_CYC(64))
      sdram_ctl_end_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .req_valid(req_valid),
      .req_write(req_write), .req_bank(req_bank), .req_row(req_row), .req_col(req_col),
      .req_wdata(req_wdata), .sleep_req(sleep_req), .power_down_req(power_down_req),
      .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .init_done(init_done),
      .link(link.ctl));
   sdram_mem_end sdram_mem_end_inst (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .link(link.mem), .in_self_refresh(in_self_refresh),
      .row_open_any(row_open_any));
   sdram_ctl_end #(.POWERUP_WAIT_CYC(20), .ROW_INTERVAL_CYC(64))
      sdram_ctl_end_at_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .req_valid(req_valid),
      .req_write(req_write), .req_bank(req_bank), .req_row(req_row), .req_col(req_col),
      .req_wdata(req_wdata), .sleep_req(sleep_req), .power_down_req(power_down_req),
      .req_ready(), .rd_valid(), .rd_data(), .init_done(), .link(link_at.ctl));
   sdram_mem_end #(.AUTOMOTIVE_GRADE(1'b1)) sdram_mem_end_at_inst (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .link(link_at.mem), .in_self_refresh(at_self_refresh),
      .row_open_any());
   sdram_link_properties
      sdram_link_properties_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .cke(link.cke),
      .cmd(link.cmd), .dq_ctl_oe(link.dq_ctl_oe), .dq_mem_oe(link.dq_mem_oe));
   // --------------------------------
   // clock, link monitor, timeout
   // --------------------------------
   always #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (link.cmd == CMD_REFRESH && link.cke === 1'b1) refs++;
      if (link.cke === 1'b0) cke_low++;
      if (at_self_refresh === 1'b1) at_seen++;
      if (cyc > 20000) begin
         bad("timeout");
         stop_test();
      end
   end
   task automatic bad(input string m);
      num_errors++;
      $display("BAD %0t %s", $time, m);
   endtask
   task automatic stop_test();
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one access, held until taken; read data returned in q
   task automatic access(input logic w, input logic [1:0] b, input logic [7:0] c,
         input logic [31:0] d);
      int n;
      n = 0;
      q = 32'hx;
      req_write = w;
      req_bank = b;
      req_row = {b, 10'h2a5};
      req_col = c;
      req_wdata = d;
      req_valid = 1'b1;
      while (req_ready !== 1'b1 && n < 500) begin
         @(negedge sys_clk);
         n++;
      end
      req_valid = 1'b0;
      if (n >= 500) bad("request never taken");
      n = 0;
      while (!w && rd_valid !== 1'b1 && n < 50) begin
         @(negedge sys_clk);
         n++;
      end
      if (!w) begin
         q = rd_data;
         checked++;
         if (n >= 50) bad("read data never returned");
         if (row_open_any !== 1'b1) bad("row closed before precharge");
      end
      @(negedge sys_clk);
   endtask
   // --------------------------------
   // scenarios
   // --------------------------------
   task automatic t_init();
      int n;
      n = 0;
      while (init_done !== 1'b1 && n < 300) begin
         @(negedge sys_clk);
         n++;
      end
      checked++;
      if (init_done !== 1'b1 || refs < 2 || cyc < 26) bad("init sequence");
      $display("test init ended");
   endtask
   task automatic t_write_read();
      access(1'b1, 2'h0, 8'h03, 32'hdead_beef);
      access(1'b1, 2'h3, 8'h0f, 32'h5a5a_a5a5);
      access(1'b0, 2'h0, 8'h03, 32'h0);
      checked++;
      if (q !== 32'hdead_beef) bad("bank 0 read back");
      access(1'b0, 2'h3, 8'h0f, 32'h0);
      checked++;
      if (q !== 32'h5a5a_a5a5) bad("bank 3 read back");
      @(negedge sys_clk);
      checked++;
      if (row_open_any !== 1'b0) bad("row open after precharge");
      $display("test write read ended");
   endtask
   task automatic t_refresh_rate();
      r0 = refs;
      repeat (256) @(negedge sys_clk);
      checked++;
      if (refs - r0 < 3) bad("too few refreshes while idle");
      $display("test refresh rate ended");
   endtask
   task automatic t_power_down();
      r0 = refs;
      cke_low = 0;
      power_down_req = 1'b1;
      repeat (300) @(negedge sys_clk);
      power_down_req = 1'b0;
      checked++;
      if (cke_low == 0 || refs - r0 < 3) bad("power-down refresh");
      access(1'b0, 2'h0, 8'h03, 32'h0);
      checked++;
      if (q !== 32'hdead_beef) bad("data lost in power-down");
      $display("test power down ended");
   endtask
   task automatic t_self_refresh();
      int n;
      n = 0;
      sleep_req = 1'b1;
      while (in_self_refresh !== 1'b1 && n < 300) begin
         @(negedge sys_clk);
         n++;
      end
      repeat (100) @(negedge sys_clk);
      checked++;
      if (in_self_refresh !== 1'b1) bad("self refresh not held");
      checked++;
      if (at_seen != 0) bad("automotive part entered self refresh");
      sleep_req = 1'b0;
      access(1'b0, 2'h3, 8'h0f, 32'h0);
      checked++;
      if (in_self_refresh !== 1'b0 || q !== 32'h5a5a_a5a5) bad("self refresh exit");
      $display("test self refresh ended");
   endtask
   // --------------------------------
   // main sequence
   // --------------------------------
   initial begin
      sys_clk = 1'b0;
      sys_rst = 1'b1;
      {req_valid, req_write, sleep_req, power_down_req} = 4'h0;
      {req_bank, req_row, req_col, req_wdata} = 54'h0;
      repeat (6) @(negedge sys_clk);
      sys_rst = 1'b0;
      t_init();
      t_write_read();
      t_refresh_rate();
      t_power_down();
      t_self_refresh();
      stop_test();
   end
endmodule
`default_nettype wire
